/* spi_fault_params.svh */
/*
  Register offsets, field positions, reset values and widths of the serial port.
  Assumes inclusion by bare name from the design module and the bench.
*/
`ifndef SPI_FAULT_PARAMS_SVH
`define SPI_FAULT_PARAMS_SVH

// Register offsets on the 3-bit register port
`define OFS_CTRL1 3'h0
`define OFS_CTRL2 3'h1
`define OFS_BAUD 3'h2
`define OFS_STATUS 3'h3
`define OFS_DATA 3'h5

// First control register fields
`define C1_ENABLE 6
`define C1_MASTER 4

// Second control register fields
`define C2_FAULT_EN 4
`define C2_BIDIR_OE 3
`define C2_STOP_WAIT 1
`define C2_BIDIR 0

// Status register fields
`define ST_XFER_DONE 7
`define ST_TX_EMPTY 5
`define ST_MODE_FAULT 4

// Reset values
`define RST_TX_EMPTY 1'h1
`define RST_DATA 8'h00

// Frame geometry
`define LAST_BIT 3'h7

`endif

/* spi_fault_pkg.sv */
/*
  Types of the serial port: register request, pin groups, transfer state and
  the module's whole state record.
  Assumes the offsets and fields come from spi_fault_params.svh.
*/
package spi_fault_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } spi_pins_t;

  typedef enum logic [1:0] {XFER_IDLE, XFER_RUN} xfer_state_t;

  typedef struct packed {
    logic [1:0] sckSync;
    logic [1:0] mosiSync;
    logic [1:0] misoSync;
    logic [1:0] ssSync;
    logic sckPrev;
    logic ssPrev;
    logic lpPrev;
    logic en;
    logic master;
    logic fden;
    logic bidir;
    logic bidirOe;
    logic swai;
    logic [7:0] baud;
    logic mode_fault_flag;
    logic transfer_complete_flag;
    logic transmit_empty_flag;
    logic modfSeen;
    logic spifSeen;
    logic sptefSeen;
    logic [7:0] txBuf;
    logic txFull;
    logic [7:0] shift;
    logic [7:0] rxData;
    logic inBit;
    logic [2:0] bitCnt;
    xfer_state_t xfer;
    logic phase;
    logic [7:0] divCnt;
    logic sckOut;
    logic pendCopy;
    logic [7:0] rdData;
  } state_t;

endpackage

/* spi_fault_core.sv */
/*
  Serial port core with mode-fault handling, low-power behaviour and the
  combined request output. Fixed 8-bit frames, clock idle low, sample on
  the rising edge, MSB first.
  Assumes a 250 MHz clock, a one-cycle register port and pins from outside
  the clock domain (synchronised here); waitMode and stopMode come from
  logic on the same clock.
*/
// Strobed register access and the register offsets were chosen for this implementation.
`include "spi_fault_params.svh"

module spi_fault_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire spi_fault_pkg::reg_req_t req,
  output logic [7:0] rdData,
  // System power state
  input wire logic waitMode,
  input wire logic stopMode,
  // Serial pins
  input wire spi_fault_pkg::spi_pins_t pinIn,
  input wire logic ssIn,
  output spi_fault_pkg::spi_pins_t pinOut,
  output spi_fault_pkg::spi_pins_t pinOe,
  // Request
  output logic irq
);

  logic [1:0] rstSync_r;
  logic rstnInt;
  spi_fault_pkg::state_t s_r;
  spi_fault_pkg::state_t s_nxt;
  logic ssS;
  logic sckS;
  logic dataInS;
  logic lp;
  logic faultNow;
  logic sckRise;
  logic sckFall;

  function automatic logic [7:0] shiftIn(input logic [7:0] v, input logic b);
    shiftIn = {v[6:0], b};
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'h1};
    end
  end
  assign rstnInt = rstSync_r[1];

  assign ssS = s_r.ssSync[1];
  assign sckS = s_r.sckSync[1];
  assign sckRise = sckS && !s_r.sckPrev;
  assign sckFall = !sckS && s_r.sckPrev;
  // Shared data pin in bidirectional mode, else the usual direction
  assign dataInS = (s_r.master == s_r.bidir) ? s_r.mosiSync[1] : s_r.misoSync[1];
  assign lp = (waitMode && s_r.swai) || stopMode;
  assign faultNow = s_r.en && s_r.master && s_r.fden && !ssS;

  always_comb begin
    s_nxt = s_r;
    s_nxt.sckSync = {s_r.sckSync[0], pinIn.sck};
    s_nxt.mosiSync = {s_r.mosiSync[0], pinIn.mosi};
    s_nxt.misoSync = {s_r.misoSync[0], pinIn.miso};
    s_nxt.ssSync = {s_r.ssSync[0], ssIn};
    s_nxt.sckPrev = sckS;
    s_nxt.ssPrev = ssS;
    s_nxt.lpPrev = lp;
    s_nxt.rdData = 8'h00;

    // registers answer even while the core is gated
    if (req.rd) begin
      case (req.addr)
        `OFS_CTRL1: begin
          s_nxt.rdData[`C1_ENABLE] = s_r.en;
          s_nxt.rdData[`C1_MASTER] = s_r.master;
        end
        `OFS_CTRL2: begin
          s_nxt.rdData[`C2_FAULT_EN] = s_r.fden;
          s_nxt.rdData[`C2_BIDIR_OE] = s_r.bidirOe;
          s_nxt.rdData[`C2_STOP_WAIT] = s_r.swai;
          s_nxt.rdData[`C2_BIDIR] = s_r.bidir;
        end
        `OFS_BAUD: s_nxt.rdData = s_r.baud;
        `OFS_STATUS: begin
          s_nxt.rdData[`ST_XFER_DONE] = s_r.transfer_complete_flag;
          s_nxt.rdData[`ST_TX_EMPTY] = s_r.transmit_empty_flag;
          s_nxt.rdData[`ST_MODE_FAULT] = s_r.mode_fault_flag;
          s_nxt.modfSeen = s_r.modfSeen || s_r.mode_fault_flag;
          s_nxt.spifSeen = s_r.spifSeen || s_r.transfer_complete_flag;
          s_nxt.sptefSeen = s_r.sptefSeen || s_r.transmit_empty_flag;
        end
        `OFS_DATA: begin
          s_nxt.rdData = s_r.rxData;
          // serviced by status read then data read
          if (s_r.spifSeen) begin
            s_nxt.transfer_complete_flag = 1'h0;
            s_nxt.spifSeen = 1'h0;
          end
        end
        default: s_nxt.rdData = 8'h00;
      endcase
    end

    if (req.wr) begin
      case (req.addr)
        `OFS_CTRL1: begin
          s_nxt.en = req.wrData[`C1_ENABLE];
          s_nxt.master = req.wrData[`C1_MASTER];
          // clear only after a status read saw the flag
          if (s_r.modfSeen) begin
            s_nxt.mode_fault_flag = 1'h0;
          end
          s_nxt.modfSeen = 1'h0;
        end
        `OFS_CTRL2: begin
          s_nxt.fden = req.wrData[`C2_FAULT_EN];
          s_nxt.bidirOe = req.wrData[`C2_BIDIR_OE];
          s_nxt.swai = req.wrData[`C2_STOP_WAIT];
          s_nxt.bidir = req.wrData[`C2_BIDIR];
        end
        `OFS_BAUD: s_nxt.baud = req.wrData;
        `OFS_DATA: begin
          // serviced by status read then data write
          if (s_r.sptefSeen) begin
            s_nxt.txBuf = req.wrData;
            s_nxt.txFull = 1'h1;
            s_nxt.transmit_empty_flag = 1'h0;
            s_nxt.sptefSeen = 1'h0;
          end
        end
        default: s_nxt.txFull = s_nxt.txFull;
      endcase
    end

    if (!s_r.en) begin
      s_nxt.xfer = spi_fault_pkg::XFER_IDLE;
      s_nxt.phase = 1'h0;
      s_nxt.sckOut = 1'h0;
      s_nxt.bitCnt = 3'h0;
      s_nxt.divCnt = 8'h00;
      s_nxt.pendCopy = 1'h0;
    end else if (faultNow) begin
      // flag set; hardware set beats a same-cycle clear
      s_nxt.mode_fault_flag = 1'h1;
      // back to slave with output buffers released
      s_nxt.master = 1'h0;
      // shared master data pin stops driving
      if (s_r.bidir) begin
        s_nxt.bidirOe = 1'h0;
      end
      s_nxt.xfer = spi_fault_pkg::XFER_IDLE;
      s_nxt.phase = 1'h0;
      s_nxt.sckOut = 1'h0;
      s_nxt.bitCnt = 3'h0;
      s_nxt.divCnt = 8'h00;
      s_nxt.pendCopy = 1'h0;
    end else if (s_r.master) begin
      // select pin unused when fault detect is off
      if (s_r.xfer == spi_fault_pkg::XFER_IDLE) begin
        if (s_r.txFull && !lp) begin
          s_nxt.shift = s_r.txBuf;
          s_nxt.txFull = 1'h0;
          s_nxt.transmit_empty_flag = 1'h1;
          s_nxt.xfer = spi_fault_pkg::XFER_RUN;
          s_nxt.divCnt = 8'h00;
          s_nxt.phase = 1'h0;
          s_nxt.bitCnt = 3'h0;
        end
      end else if (!lp) begin
        // divider and shifter only advance outside low power
        if (s_r.divCnt == s_r.baud) begin
          s_nxt.divCnt = 8'h00;
          s_nxt.phase = !s_r.phase;
          if (!s_r.phase) begin
            s_nxt.sckOut = 1'h1;
            s_nxt.inBit = dataInS;
          end else begin
            s_nxt.sckOut = 1'h0;
            s_nxt.shift = shiftIn(s_r.shift, s_r.inBit);
            s_nxt.bitCnt = s_r.bitCnt + 3'h1;
            if (s_r.bitCnt == `LAST_BIT) begin
              s_nxt.rxData = shiftIn(s_r.shift, s_r.inBit);
              s_nxt.transfer_complete_flag = 1'h1;
              s_nxt.xfer = spi_fault_pkg::XFER_IDLE;
            end
          end
        end else begin
          s_nxt.divCnt = s_r.divCnt + 8'h01;
        end
      end
    end else begin
      // slave treats select only as a select
      if (ssS) begin
        s_nxt.bitCnt = 3'h0;
        s_nxt.xfer = spi_fault_pkg::XFER_IDLE;
      end else begin
        if (s_r.ssPrev) begin
          s_nxt.xfer = spi_fault_pkg::XFER_RUN;
          // Without a new byte the last one received goes back out
          if (s_r.txFull) begin
            s_nxt.shift = s_r.txBuf;
            s_nxt.txFull = 1'h0;
            s_nxt.transmit_empty_flag = 1'h1;
          end
        end
        // shifting follows the external clock in any power state
        if (sckRise) begin
          s_nxt.inBit = dataInS;
        end
        if (sckFall) begin
          s_nxt.shift = shiftIn(s_r.shift, s_r.inBit);
          s_nxt.bitCnt = s_r.bitCnt + 3'h1;
          if (s_r.bitCnt == `LAST_BIT) begin
            // held back while in low power
            if (lp) begin
              s_nxt.pendCopy = 1'h1;
            end else begin
              s_nxt.rxData = shiftIn(s_r.shift, s_r.inBit);
              s_nxt.transfer_complete_flag = 1'h1;
            end
          end
        end
      end
      // a byte still pending at entry is lost
      if (lp && !s_r.lpPrev) begin
        s_nxt.pendCopy = 1'h0;
      end
      // a byte completed after low-power entry is delivered at exit
      if (!lp && s_r.pendCopy) begin
        s_nxt.pendCopy = 1'h0;
        s_nxt.rxData = s_r.shift;
        s_nxt.transfer_complete_flag = 1'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstnInt) begin
    if (!rstnInt) begin
      s_r <= '0;
      s_r.transmit_empty_flag <= `RST_TX_EMPTY;
      s_r.rxData <= `RST_DATA;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdData = s_r.rdData;
  assign pinOut.sck = s_r.sckOut;
  assign pinOut.mosi = s_r.shift[7];
  assign pinOut.miso = s_r.shift[7];
  // nothing drives while a fault is flagged
  assign pinOe.sck = s_r.en && s_r.master && !s_r.mode_fault_flag;
  assign pinOe.mosi = s_r.en && s_r.master && !s_r.mode_fault_flag && (!s_r.bidir || s_r.bidirOe);
  assign pinOe.miso = s_r.en && !s_r.master && !s_r.mode_fault_flag && !ssS &&
                      (!s_r.bidir || s_r.bidirOe);
  // one request from three flags, only when enabled
  assign irq = s_r.en && (s_r.mode_fault_flag || s_r.transfer_complete_flag || s_r.transmit_empty_flag);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstnInt);

  a_fault_sets_flag: assert property (faultNow |=> s_r.mode_fault_flag && !s_r.master)
    else $error("fault did not set flag or clear master");
  a_fault_off_ignored: assert property (s_r.master && !s_r.fden && !s_r.mode_fault_flag |=> !s_r.mode_fault_flag)
    else $error("fault flagged with detection off");
  a_slave_no_fault: assert property (!s_r.master && !s_r.mode_fault_flag |=> !s_r.mode_fault_flag)
    else $error("slave raised a mode fault");
  a_fault_pins_free: assert property (s_r.mode_fault_flag |-> !pinOe.sck && !pinOe.mosi && !pinOe.miso)
    else $error("pin driven during fault");
  a_fault_to_idle: assert property (faultNow |=> s_r.xfer == spi_fault_pkg::XFER_IDLE
                                      && s_r.bitCnt == 3'h0)
    else $error("transfer not aborted on fault");
  a_fault_no_copy: assert property (faultNow |=> $stable(s_r.rxData) && !$rose(s_r.transfer_complete_flag))
    else $error("byte delivered on fault");
  a_bidir_oe_drop: assert property (faultNow && s_r.bidir |=> !s_r.bidirOe)
    else $error("shared pin enable kept after fault");
  a_fault_clear_seq: assert property ($fell(s_r.mode_fault_flag) |-> $past(req.wr) &&
                                      $past(req.addr) == `OFS_CTRL1 && $past(s_r.modfSeen))
    else $error("fault cleared without the sequence");
  a_master_freeze: assert property (s_r.en && s_r.master && lp && !faultNow &&
                                    s_r.xfer == spi_fault_pkg::XFER_RUN
                                    |=> $stable(s_r.bitCnt) && $stable(s_r.sckOut))
    else $error("master advanced in low power");
  a_slave_lp_hold: assert property (s_r.en && !s_r.master && lp ##1 lp |-> !$rose(s_r.transfer_complete_flag))
    else $error("slave flagged completion in low power");
  a_irq_gated: assert property (!s_r.en |-> !irq)
    else $error("request while disabled");
  a_fault_irq: assert property (s_r.en && s_r.mode_fault_flag |-> irq)
    else $error("fault request withdrawn early");
  a_done_held: assert property (s_r.transfer_complete_flag && !(req.rd && req.addr == `OFS_DATA)
                                |=> s_r.transfer_complete_flag)
    else $error("complete flag dropped unserviced");
  a_empty_held: assert property (s_r.transmit_empty_flag && !(req.wr && req.addr == `OFS_DATA)
                                 |=> s_r.transmit_empty_flag)
    else $error("empty flag dropped unserviced");

  c_mode_fault: cover property (faultNow ##1 s_r.mode_fault_flag);
  c_master_done: cover property (s_r.master && $rose(s_r.transfer_complete_flag));
  c_slave_deferred: cover property ($fell(s_r.pendCopy) ##1 s_r.transfer_complete_flag);
  c_fault_cleared: cover property ($fell(s_r.mode_fault_flag));
  // The shared data pin case is the one most easily left unexercised
  c_bidir_fault: cover property (faultNow && s_r.bidir && s_r.bidirOe
                                 ##1 !s_r.bidirOe);

endmodule

/* spi_ext_partner.sv */
/*
  Behavioural model of the external serial device facing the port: a mode-0
  slave that answers a master transfer, and a master that clocks a slave.
  Assumes the bench resolves the shared pins and hands back the wire levels.
*/
module spi_ext_partner (
  // Wire levels seen on the link
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  // Levels this model drives while the port is not driving
  output logic sckP,
  output logic mosiP,
  output logic misoP,
  output logic ssN
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sTx;
  logic [7:0] sRx;
  logic sAct;
  int sCnt;

  initial begin
    sckP = 1'b0;
    mosiP = 1'b0;
    misoP = 1'b0;
    ssN = 1'b1;
    sAct = 1'b0;
    sCnt = 0;
    sRx = 8'h00;
  end

  task slave_load(input logic [7:0] b);
    sTx = b;
    sCnt = 0;
    sAct = 1'b1;
    misoP = b[7];
  endtask

  always @(posedge sck) begin
    if (sAct) begin
      sRx = {sRx[6:0], mosi};
      sCnt++;
    end
  end

  // A released data line must not keep showing the last bit
  always @(negedge sck) begin
    if (sAct && sCnt == 8) begin
      sAct = 1'b0;
      misoP = ~misoP;
    end else if (sAct) begin
      misoP = sTx[7 - sCnt];
    end
  end

  // Link clock stands low outside frames, 32 ns period
  task master_xfer(input logic [7:0] b, output logic [7:0] r);
    ssN = 1'b0;
    #32;
    for (int i = 7; i >= 0; i--) begin
      mosiP = b[i];
      #16;
      sckP = 1'b1;
      r[i] = miso;
      #16;
      sckP = 1'b0;
    end
    #16;
    mosiP = ~mosiP;
    ssN = 1'b1;
  endtask
endmodule

/* tb_spi_fault_lowpower_irq.sv */
/*
  Self-checking bench of the serial port core: register port, master and
  slave transfers, mode fault, low power and the request output.
  Assumes spi_ext_partner stands on the link and the design's header.
*/
`include "spi_fault_params.svh"

module tb_spi_fault_lowpower_irq;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic waitMode = 1'b0;
  logic stopMode = 1'b0;
  spi_fault_pkg::reg_req_t req = '0;
  spi_fault_pkg::spi_pins_t pinIn;
  spi_fault_pkg::spi_pins_t pinOut;
  spi_fault_pkg::spi_pins_t pinOe;
  logic [7:0] rdData;
  logic irq;
  logic sckP, mosiP, misoP, ssN;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h435B7CA2;
  logic [7:0] rxQ[$];
  logic [7:0] d, got, tx;

  always #2 clock = ~clock;

  assign pinIn = '{sck: pinOe.sck ? pinOut.sck : sckP,
                   mosi: pinOe.mosi ? pinOut.mosi : mosiP,
                   miso: pinOe.miso ? pinOut.miso : misoP};

  spi_fault_core uut (.clock(clock), .rstn(rstn), .req(req), .rdData(rdData),
    .waitMode(waitMode), .stopMode(stopMode), .pinIn(pinIn), .ssIn(ssN),
    .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

  spi_ext_partner partner (.sck(pinIn.sck), .mosi(pinIn.mosi), .miso(pinIn.miso),
    .sckP(sckP), .mosiP(mosiP), .misoP(misoP), .ssN(ssN));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task report_and_stop;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock);
    req <= '{addr: a, wrData: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clock);
    req <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 v = rdData;
  endtask

  task wait_flag(input int b);
    int k;
    for (k = 0; k < 300; k++) begin
      rd(`OFS_STATUS, d);
      if (d[b] === 1'b1) break;
    end
    if (k == 300) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  // Master byte; how 1 freezes by wait, 2 by stop, mid-frame
  task mxfer(input int how);
    logic [7:0] t, s;
    t = rnd();
    rxQ.push_back(rnd());
    partner.slave_load(rxQ[0]);
    wait_flag(`ST_TX_EMPTY);
    wr(`OFS_DATA, t);
    if (how != 0) begin
      repeat (40) @(posedge clock);
      waitMode <= (how == 1);
      stopMode <= (how == 2);
      repeat (4) @(posedge clock);
      #1 s = pinOut.sck;
      repeat (50) @(posedge clock);
      #1 chk1(pinOut.sck, s); // clock held still
      @(posedge clock);
      waitMode <= 1'b0;
      stopMode <= 1'b0;
    end
    wait_flag(`ST_XFER_DONE);
    rd(`OFS_DATA, d);
    chk8(d, rxQ.pop_front()); // received byte
    chk8(partner.sRx, t); // sent byte
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`OFS_DATA, d);
    chk8(d, `RST_DATA); // zero after reset
    rd(`OFS_STATUS, d);
    chk8(d, 8'h20); // empty after reset
    chk1(irq, 1'b0); // quiet while disabled
    wr(`OFS_BAUD, 8'h07);
    rd(`OFS_BAUD, d);
    chk8(d, 8'h07); // registers live while disabled
    wr(`OFS_CTRL2, 8'h10);
    wr(`OFS_CTRL1, 8'h50);
    #1;
    chk1(irq, 1'b1); // empty raises request
    waitMode <= 1'b1;
    mxfer(0); // wait without stop-in-wait
    waitMode <= 1'b0;
    mxfer(2); // stop freeze
    wr(`OFS_CTRL2, 8'h12);
    mxfer(1); // wait freeze
    // Select pulled low mid-transfer in bidirectional master mode
    wr(`OFS_CTRL2, 8'h19);
    partner.slave_load(rnd());
    wait_flag(`ST_TX_EMPTY);
    wr(`OFS_DATA, rnd());
    repeat (40) @(posedge clock);
    partner.ssN <= 1'b0;
    repeat (10) @(posedge clock);
    rd(`OFS_STATUS, d);
    chk8(d & 8'h90, 8'h10); // fault set, no copy
    chk8({5'h00, pinOe}, 8'h00); // pins released
    rd(`OFS_CTRL2, d);
    chk8(d & 8'h08, 8'h00); // data pin enable dropped
    rd(`OFS_CTRL1, d);
    chk8(d, 8'h40); // master bit cleared
    chk1(irq, 1'b1); // request held
    @(posedge clock);
    partner.ssN <= 1'b1;
    rd(`OFS_STATUS, d);
    wr(`OFS_CTRL1, 8'h40); // service sequence
    repeat (150) @(posedge clock);
    rd(`OFS_STATUS, d);
    chk8(d & 8'h90, 8'h00); // fault cleared, no late copy
    wr(`OFS_CTRL2, 8'h00);
    wr(`OFS_CTRL1, 8'h50);
    partner.ssN <= 1'b0;
    repeat (10) @(posedge clock);
    rd(`OFS_STATUS, d);
    chk8(d & 8'h10, 8'h00); // select ignored
    @(posedge clock);
    partner.ssN <= 1'b1;
    // Slave byte with wait entered mid-frame and stop-in-wait set
    wr(`OFS_CTRL1, 8'h40);
    wr(`OFS_CTRL2, 8'h02);
    tx = rnd();
    rxQ.push_back(rnd());
    wait_flag(`ST_TX_EMPTY);
    wr(`OFS_DATA, tx);
    fork
      partner.master_xfer(rxQ[0], got);
      begin
        repeat (30) @(posedge clock);
        waitMode <= 1'b1;
      end
    join
    repeat (10) @(posedge clock);
    rd(`OFS_STATUS, d);
    chk8(d & 8'h90, 8'h00); // no flag in wait, no fault
    @(posedge clock);
    waitMode <= 1'b0;
    wait_flag(`ST_XFER_DONE);
    rd(`OFS_DATA, d);
    chk8(d, rxQ.pop_front()); // copy after wait exit
    chk8(got, tx); // loaded byte kept going out
    @(posedge clock);
    waitMode <= 1'b1;
    repeat (10) @(posedge clock);
    waitMode <= 1'b0;
    repeat (10) @(posedge clock);
    rd(`OFS_STATUS, d);
    chk8(d & 8'h80, 8'h00); // idle wait gives no copy
    wr(`OFS_CTRL1, 8'h00);
    #1;
    chk1(irq, 1'b0); // disable withdraws request
    report_and_stop();
  end
endmodule
